//--- core/rise_detect.sv
// Rising edge detector between two successive accepted words.
`timescale 1ns/100ps
module rise_detect #(
    parameter int WIDTH = 2
) (
    input  wire logic [WIDTH-1:0] i_prev,
    input  wire logic [WIDTH-1:0] i_curr,
    output logic      [WIDTH-1:0] o_rise
);
    // Each bit rises when it was low in the old word and high in the new.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign o_rise[g] = i_curr[g] & ~i_prev[g];
        end
    endgenerate
endmodule : rise_detect

//--- core/speed_ctl_pkg.sv
// Constants and types shared by the speed profile control word decoder.
package speed_ctl_pkg;
    localparam int CTL_WIDTH     = 16;
    localparam int PRESET_LO     = 0;
    localparam int PRESET_HI     = 1;
    localparam int COAST_BIT     = 3;
    localparam int QSTOP_BIT     = 4;
    localparam int FREEZE_BIT    = 5;
    localparam int START_BIT     = 6;
    localparam int RESET_BIT     = 7;
    localparam int RAMP_BIT      = 9;
    localparam int VALID_BIT     = 10;
    localparam int DIN_LO        = 12;
    localparam int DIN_HI        = 15;
    localparam int DIN_COUNT     = 4;
    // Safe word after reset: coast and quick stop asserted, nothing running.
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // Stop method chosen by the missing-start setting.
    typedef enum logic [1:0] {
        STOP_RAMP  = 2'h0,
        STOP_COAST = 2'h1,
        STOP_QUICK = 2'h2
    } stop_method_t;
endpackage : speed_ctl_pkg

//--- core/speed_profile_control_word.sv
// Decoder for the speed profile control word written by the fieldbus master.
`timescale 1ns/100ps
module speed_profile_control_word
    import speed_ctl_pkg::*;
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic [CTL_WIDTH-1:0] i_ctl_word,
    input  wire logic                 i_ctl_write,
    input  wire logic                 i_fieldbus_place,
    input  wire logic [1:0]           i_missing_start_method,
    output logic      [1:0]           o_preset_sel,
    output logic                      o_coast_req,
    output logic                      o_quick_stop_req,
    output logic                      o_ref_freeze,
    output logic                      o_run,
    output logic                      o_start_pulse,
    output logic      [1:0]           o_stop_method,
    output logic                      o_event_reset_pulse,
    output logic                      o_ramp2_sel,
    output logic      [DIN_COUNT-1:0] o_fieldbus_din,
    output logic                      o_ctl_accepted
);
    // Two bits of the word act on edges rather than on levels.
    localparam int EDGE_COUNT = 2;
    // Position of the start bit inside the edge vector.
    localparam int EDGE_START = 0;
    // Position of the event reset bit inside the edge vector.
    localparam int EDGE_RESET = 1;

    // Held copy of the most recently accepted word.
    logic [CTL_WIDTH-1:0]  word_reg;
    // The accepted word before that one, for edge detection.
    logic [CTL_WIDTH-1:0]  prev_reg;
    // Edge-triggered bits picked out of the two held words.
    logic [EDGE_COUNT-1:0] edge_prev;
    logic [EDGE_COUNT-1:0] edge_curr;
    // Rising edges between the two held words.
    logic [EDGE_COUNT-1:0] rise;
    // Digital input bits gathered before they are registered.
    logic [DIN_COUNT-1:0]  din_next;
    // High in the cycle a valid write arrives.
    logic                  accept;
    // High while the fieldbus owns the control place.
    logic                  cmd_ok;
    // High while the held word or the control place forbids running.
    logic                  stop_now;

    // True while any condition asks the drive to stop or stay stopped.
    // The run flag and the start pulse both use it, so they can never
    // disagree about whether a start edge is allowed to take effect.
    function automatic logic stop_requested(
        input logic [CTL_WIDTH-1:0] word,
        input logic                 place
    );
        stop_requested = !place || !word[START_BIT] ||
                         !word[COAST_BIT] || !word[QSTOP_BIT];
    endfunction : stop_requested

    // An active-low request bit becomes an active-high request, but only
    // while the fieldbus is in command; otherwise it is not acknowledged.
    function automatic logic low_request(
        input logic level,
        input logic place
    );
        low_request = place & ~level;
    endfunction : low_request

    // Data valid gates each write; reserved bits are simply never read.
    assign accept = i_ctl_write & i_ctl_word[VALID_BIT];

    // Start, coast and quick stop commands matter only while the fieldbus owns the control place.
    assign cmd_ok = i_fieldbus_place;

    // One shared stop decision for the run flag and the start pulse.
    assign stop_now = stop_requested(word_reg, cmd_ok);

    // Last accepted word is held until a valid write replaces it, so a
    // refused write leaves every level output exactly where it was.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            word_reg <= CTL_RESET;
        end else if (accept) begin
            word_reg <= i_ctl_word;
        end
    end

    // The previous word moves only with an accepted write; an ignored
    // write therefore can neither create nor hide an edge.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            prev_reg <= CTL_RESET;
        end else if (accept) begin
            prev_reg <= word_reg;
        end
    end

    // Gather the edge-triggered bits of both words side by side.
    assign edge_prev[EDGE_START] = prev_reg[START_BIT];
    assign edge_prev[EDGE_RESET] = prev_reg[RESET_BIT];
    assign edge_curr[EDGE_START] = word_reg[START_BIT];
    assign edge_curr[EDGE_RESET] = word_reg[RESET_BIT];

    // Edges are judged on the accepted pair, so ignored writes never fake one.
    rise_detect #(
        .WIDTH (EDGE_COUNT)
    ) u_rise (
        .i_prev (edge_prev),
        .i_curr (edge_curr),
        .o_rise (rise)
    );

    // A one-cycle marker so edges are taken once per accepted word.
    // Without it a held rising pair would restart the drive every cycle.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ctl_accepted <= 1'b0;
        end else begin
            o_ctl_accepted <= accept;
        end
    end

    // Preset selector follows the held word's two low bits.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_preset_sel <= 2'h0;
        end else begin
            o_preset_sel <= word_reg[PRESET_HI:PRESET_LO];
        end
    end

    // Coast request; it resets active so the drive starts out safe.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_coast_req <= 1'b1;
        end else begin
            o_coast_req <= low_request(word_reg[COAST_BIT], cmd_ok);
        end
    end

    // Quick stop request; it also resets active.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_quick_stop_req <= 1'b1;
        end else begin
            o_quick_stop_req <= low_request(word_reg[QSTOP_BIT], cmd_ok);
        end
    end

    // Reference freeze; the reference stays frozen until a word frees it.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ref_freeze <= 1'b1;
        end else begin
            o_ref_freeze <= ~word_reg[FREEZE_BIT];
        end
    end

    // Ramp choice: low picks the first ramp, high the second.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ramp2_sel <= 1'b0;
        end else begin
            o_ramp2_sel <= word_reg[RAMP_BIT];
        end
    end

    // Each fieldbus digital input is an independent copy of one bit.
    generate
        for (genvar b = 0; b < DIN_COUNT; b++) begin : g_din
            assign din_next[b] = word_reg[DIN_LO + b];
        end
    endgenerate

    // The four inputs are registered together so they change as a set.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_fieldbus_din <= '0;
        end else begin
            o_fieldbus_din <= din_next;
        end
    end

    // The stop method is a plain registered copy of the setting; the
    // consumer applies it whenever the run flag drops.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_stop_method <= STOP_RAMP;
        end else begin
            o_stop_method <= i_missing_start_method;
        end
    end

    // Run starts on the start edge and ends whenever start is low or
    // a stop request is present; the latter also blocks starting. A start
    // edge that arrives while blocked is lost, and the master must lower
    // and raise the start bit again once the block is gone.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_run <= 1'b0;
        end else if (stop_now) begin
            o_run <= 1'b0;
        end else if (o_ctl_accepted && rise[EDGE_START]) begin
            o_run <= 1'b1;
        end
    end

    // Start pulse marks the cycle in which the run flag rises.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_start_pulse <= 1'b0;
        end else begin
            o_start_pulse <= !stop_now && o_ctl_accepted &&
                             rise[EDGE_START];
        end
    end

    // Event reset is a single pulse per accepted rising edge.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_event_reset_pulse <= 1'b0;
        end else begin
            o_event_reset_pulse <= o_ctl_accepted & rise[EDGE_RESET];
        end
    end
endmodule : speed_profile_control_word

//--- sim/fieldbus_master_model.sv
// Fieldbus master model that writes control words.
`timescale 1ns/100ps
module fieldbus_master_model (
    input  wire logic        i_ref_clk,
    output logic      [15:0] o_word = 16'h0,
    output logic             o_write = 1'b0
);
    // One write per call; afterwards the word is inverted, so stale data
    // after a valid word never looks like a good word.
    task automatic send(input logic [15:0] w, input bit raw);
        @(posedge i_ref_clk) #1;
        o_write = 1'b1;
        o_word  = raw ? w : w & 16'hf6fb;
        @(posedge i_ref_clk) #1;
        o_write = 1'b0;
        o_word  = ~o_word;
    endtask : send
endmodule : fieldbus_master_model

//--- sim/speed_profile_control_word_properties.sv
// Port checker for the control word decoder.
`timescale 1ns/100ps
module speed_profile_control_word_props import speed_ctl_pkg::*; (
    input wire logic i_ref_clk, i_rst_n, i_ctl_write, i_fieldbus_place,
    input wire logic [CTL_WIDTH-1:0] i_ctl_word,
    input wire logic [1:0] i_missing_start_method, o_preset_sel,
    input wire logic [1:0] o_stop_method,
    input wire logic o_coast_req, o_quick_stop_req, o_ref_freeze, o_run,
    input wire logic o_start_pulse, o_event_reset_pulse, o_ramp2_sel,
    input wire logic [DIN_COUNT-1:0] o_fieldbus_din,
    input wire logic o_ctl_accepted);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // A write counts only with the valid bit set.
    wire acc = i_ctl_write & i_ctl_word[VALID_BIT];
    sequence s_write; acc ##1 o_ctl_accepted; endsequence
    AST_ACCEPT: assert property (acc |=> o_ctl_accepted)
        else $error("write lost");
    AST_DROP: assert property (!acc |=> !o_ctl_accepted)
        else $error("bad accept");
    AST_PRESET: assert property (s_write |=>
        o_preset_sel == $past(i_ctl_word[1:0], 2)) else $error("preset");
    AST_RAMP: assert property (s_write |=>
        o_ramp2_sel == $past(i_ctl_word[9], 2)) else $error("ramp");
    AST_DIN: assert property (s_write |=>
        o_fieldbus_din == $past(i_ctl_word[15:12], 2)) else $error("din");
    AST_FREEZE: assert property (s_write |=>
        o_ref_freeze == !$past(i_ctl_word[5], 2)) else $error("freeze");
    AST_COAST: assert property (s_write ##1 $past(i_fieldbus_place) |->
        o_coast_req == !$past(i_ctl_word[3], 2))
        else $error("coast");
    AST_OFF: assert property (!i_fieldbus_place [*2] |->
        !o_coast_req && !o_quick_stop_req && !o_run) else $error("place");
    AST_HOLD: assert property (!$past(o_ctl_accepted) && $past(i_rst_n) |->
        $stable({o_preset_sel, o_fieldbus_din})) else $error("hold");
    AST_START: assert property (o_start_pulse |->
        $past(o_ctl_accepted) && o_run ##1 !o_start_pulse) else $error("st");
    AST_EVRST: assert property (o_event_reset_pulse |->
        $past(o_ctl_accepted) ##1 !o_event_reset_pulse) else $error("evr");
    AST_STOP: assert property (acc && !i_ctl_word[START_BIT] |=>
        ##1 !o_run) else $error("stop");
endmodule : speed_profile_control_word_props
bind speed_profile_control_word speed_profile_control_word_props u_p (.*);

//--- sim/speed_profile_control_word_tb_top.sv
// Self-checking bench for the control word decoder.
`timescale 1ns/100ps
module speed_profile_control_word_tb_top;
    logic clk = 0, rst_n = 0, place = 1;
    logic [1:0] meth = 2'h2, pre, stm;
    int fail_count = 0, n_tests = 0;
    wire [15:0] word;
    wire wr, acc, start, evr, run, cst, qst, frz, r2;
    wire [3:0] din;
    wire [9:0] lv = {pre, frz, r2, din, cst, qst};
    typedef struct packed { logic [15:0] w; logic [9:0] e; } row_t;
    row_t rows [4] = '{'{16'h0418, 10'h080}, '{16'h1621, 10'h147},
                       '{16'ha43a, 10'h228}, '{16'h5f1b, 10'h3d4}};
    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;
    speed_profile_control_word DUT (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_ctl_word(word), .i_ctl_write(wr), .i_fieldbus_place(place),
        .i_missing_start_method(meth), .o_preset_sel(pre), .o_run(run),
        .o_coast_req(cst), .o_quick_stop_req(qst), .o_ref_freeze(frz),
        .o_start_pulse(start), .o_stop_method(stm), .o_ramp2_sel(r2),
        .o_event_reset_pulse(evr), .o_fieldbus_din(din),
        .o_ctl_accepted(acc));
    fieldbus_master_model m (.i_ref_clk(clk), .o_word(word), .o_write(wr));
    task automatic chk(input logic [10:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d failures %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // One write, its accept marker while it stands, then one more edge
    // so the held outputs and any edge pulses are all updated.
    task automatic put(input logic [15:0] w, input bit raw);
        m.send(w, raw);
        chk(acc, w[10]);
        @(posedge clk) #1;
    endtask : put
    // Main sequence: table rows first, then start, stop and place cases.
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1;
        chk({run, lv}, 11'h083);
        foreach (rows[i]) begin
            put(rows[i].w, 1'b1);
            chk({run, lv}, {1'b0, rows[i].e});
        end
        put(16'h0003, 1'b1);
        chk(lv, 10'h3d4);
        put(16'h0458, 1'b0);
        chk({start, run, stm, evr}, 5'h1c);
        @(posedge clk) #1;
        chk({start, run}, 2'h1);
        meth = 2'h1;
        put(16'h0418, 1'b0);
        chk({run, stm}, 3'h1);
        put(16'h0498, 1'b0);
        chk({evr, start, run}, 3'h4);
        @(posedge clk) #1;
        chk(evr, 1'b0);
        place = 0;
        put(16'h0400, 1'b0);
        chk({cst, qst}, 2'h0);
        put(16'h0458, 1'b0);
        chk({start, run}, 2'h0);
        rst_n = 0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1;
        chk({run, lv}, 11'h083);
        results();
    end
    // Watchdog: the sequence needs well under a hundred cycles.
    initial begin
        #20000;
        fail_count++;
        results();
    end
endmodule : speed_profile_control_word_tb_top
